// >>> hdl/owlr_pkg.sv
package owlr_pkg;
	// clock period
	localparam int CLK_PERIOD_NS = 10;
	// device address byte, sent msb first
	localparam logic [7:0] DEV_ADDR = 8'h72;
	// data byte field positions
	localparam int ACK_REQ_POS  = 7;
	localparam int SUB_HI_POS   = 6;
	localparam int SUB_LO_POS   = 5;
	localparam int LEVEL_MSB    = 4;
	// stored level after power reset: full scale
	localparam logic [4:0] LEVEL_RESET = 5'h1F;
	localparam int FRAME_BITS   = 16;
	// times in their own units
	localparam int START_TIME_NS         = 2000;
	localparam int END_OF_STREAM_TIME_NS = 2000;
	localparam int ACK_PULSE_TIME_NS     = 512000;
	localparam int ACK_VALID_DELAY_NS    = 2000;
	localparam int MODE_DETECT_DELAY_US  = 100;
	localparam int MODE_DETECT_LOW_TIME_US = 260;
	localparam int MODE_DETECT_WINDOW_US = 1000;
	localparam int SHUTDOWN_TIME_US      = 2500;
	// cycle counts: longest times round down, least times round up
	localparam int ACK_PULSE_CYCLES   = ACK_PULSE_TIME_NS / CLK_PERIOD_NS;
	localparam int ACK_VALID_CYCLES   = (ACK_VALID_DELAY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int EOS_CYCLES         = (END_OF_STREAM_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int MODE_DELAY_CYCLES  = (MODE_DETECT_DELAY_US * 1000) / CLK_PERIOD_NS;
	localparam int MODE_LOW_CYCLES    = (MODE_DETECT_LOW_TIME_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int MODE_WINDOW_CYCLES = (MODE_DETECT_WINDOW_US * 1000) / CLK_PERIOD_NS;
	localparam int SHUTDOWN_CYCLES    = (SHUTDOWN_TIME_US * 1000) / CLK_PERIOD_NS;
	localparam int CNT_W = 20;
	localparam int SYNC_STAGES = 3;

	typedef enum logic [2:0]
	{
		OWLR_OFF    = 3'b000,
		OWLR_DETECT = 3'b001,
		OWLR_PWM    = 3'b010,
		OWLR_IDLE   = 3'b011,
		OWLR_BITS   = 3'b100,
		OWLR_ACKWT  = 3'b101,
		OWLR_ACK    = 3'b110
	} owlr_state_t;
endpackage

// >>> hdl/owlr_sync.sv
`timescale 1ns/1ps
module owlr_sync
	import owlr_pkg::*;
(
	// clock and reset
	input  wire logic CLK_IN,
	input  wire logic RESETN_IN,
	// raw pin and filtered level
	input  wire logic PIN_IN,
	output logic      LEVEL_OUT
);
	logic [SYNC_STAGES-1:0] stage;
	logic [SYNC_STAGES-1:0] next_stage;
	logic                   level;
	logic                   next_level;

	// a change counts only once the second and third stage agree
	always_comb
	begin
		next_stage = {stage[SYNC_STAGES-2:0], PIN_IN};
		next_level = (stage[1] == stage[2]) ? stage[2] : level;
	end

	// line idles high through the pull-up
	always_ff @(posedge CLK_IN or negedge RESETN_IN)
	begin
		if (!RESETN_IN)
		begin
			stage <= 3'h7;
			level <= 1'h1;
		end
		else
		begin
			stage <= next_stage;
			level <= next_level;
		end
	end

	assign LEVEL_OUT = level;
endmodule

// >>> hdl/owlr_top.sv
`timescale 1ns/1ps
module owlr_top
	import owlr_pkg::*;
#(
	parameter int ACK_PULSE  = ACK_PULSE_CYCLES,
	parameter int MODE_DELAY = MODE_DELAY_CYCLES,
	parameter int MODE_LOW   = MODE_LOW_CYCLES,
	parameter int MODE_WIN   = MODE_WINDOW_CYCLES,
	parameter int SHUTDOWN   = SHUTDOWN_CYCLES
)
(
	// clock and reset
	input  wire logic       CLK_IN,
	input  wire logic       RESETN_IN,
	// control line, open drain acknowledge
	input  wire logic       CTRL_IN,
	output logic            CTRL_OUT,
	output logic            CTRL_OE_OUT,
	// status
	output logic [4:0]      LEVEL_OUT,
	output logic            ENABLED_OUT,
	output logic            ONE_WIRE_MODE_OUT,
	output logic            FRAME_DONE_OUT
);
	owlr_state_t      state;
	owlr_state_t      next_state;
	logic [CNT_W-1:0] cnt;
	logic [CNT_W-1:0] next_cnt;
	logic [CNT_W-1:0] low_cnt;
	logic [CNT_W-1:0] next_low_cnt;
	logic [CNT_W-1:0] high_cnt;
	logic [CNT_W-1:0] next_high_cnt;
	logic [CNT_W-1:0] win_cnt;
	logic [CNT_W-1:0] next_win_cnt;
	logic [15:0]      shift;
	logic [15:0]      next_shift;
	logic [4:0]       nbits;
	logic [4:0]       next_nbits;
	logic [4:0]       level;
	logic [4:0]       next_level;
	logic             done;
	logic             next_done;
	logic             data_open;
	logic             next_data_open;
	logic             line;
	logic             line_d;
	logic             fall;
	logic             rise;
	logic             valid;

	owlr_sync owlr_sync_i
	(
		.CLK_IN    (CLK_IN),
		.RESETN_IN (RESETN_IN),
		.PIN_IN    (CTRL_IN),
		.LEVEL_OUT (line)
	);

	always_ff @(posedge CLK_IN or negedge RESETN_IN)
	begin
		if (!RESETN_IN)
			line_d <= 1'h1;
		else
			line_d <= line;
	end

	assign fall = line_d & ~line;
	assign rise = ~line_d & line;

	function automatic logic [CNT_W-1:0] sat_inc(input logic [CNT_W-1:0] v);
		sat_inc = (&v) ? v : v + 1'h1;
	endfunction

	// address, sub-address and count all checked
	assign valid = (nbits == 5'(FRAME_BITS)) && (shift[15:8] == DEV_ADDR)
		&& !shift[SUB_HI_POS] && !shift[SUB_LO_POS];

	always_comb
	begin
		next_state    = state;
		next_cnt      = sat_inc(cnt);
		next_low_cnt  = low_cnt;
		next_high_cnt = high_cnt;
		next_win_cnt  = sat_inc(win_cnt);
		next_shift    = shift;
		next_nbits    = nbits;
		next_level    = level;
		next_done     = 1'h0;
		next_data_open = data_open;
		// a long low shuts the device down from any mode
		if (state != OWLR_OFF && state != OWLR_ACK && !line && cnt >= CNT_W'(SHUTDOWN - 1)
			&& state != OWLR_BITS && state != OWLR_ACKWT)
			next_state = OWLR_OFF;
		case (state)
			OWLR_OFF:
			begin
				next_cnt = '0;
				next_win_cnt = '0;
				if (rise)
					next_state = OWLR_DETECT;
			end
			// low longer than detect time, after delay, inside window
			OWLR_DETECT:
			begin
				if (fall)
					next_cnt = '0;
				if (!line && win_cnt >= CNT_W'(MODE_DELAY) && cnt >= CNT_W'(MODE_LOW))
					next_state = OWLR_IDLE;
				else if (win_cnt >= CNT_W'(MODE_WIN))
					next_state = OWLR_PWM;
			end
			OWLR_PWM:
			begin
				if (fall || rise)
					next_cnt = '0;
			end
			// high line counts as start, first fall opens the address byte
			OWLR_IDLE:
			begin
				if (fall)
				begin
					next_cnt = '0;
					next_low_cnt = '0;
					next_high_cnt = '0;
					next_nbits = '0;
					next_data_open = 1'h0;
					next_state = OWLR_BITS;
				end
				else if (rise)
					next_cnt = '0;
			end
			OWLR_BITS:
			begin
				// phase lengths counted on the internal clock
				if (line)
					next_high_cnt = sat_inc(high_cnt);
				else
					next_low_cnt = sat_inc(low_cnt);
				// a falling edge closes the bit
				if (fall)
				begin
					next_low_cnt = '0;
					next_high_cnt = '0;
					next_cnt = '0;
					// the fall after the gap between bytes only opens the data byte
					if (nbits == 5'(FRAME_BITS / 2) && !data_open)
						next_data_open = 1'h1;
					else
					begin
						next_shift = {shift[14:0], high_cnt > low_cnt};
						next_nbits = nbits + 5'h01;
					end
				end
				// too many bits: drop the frame instead of wrapping the count
				else if (nbits > 5'(FRAME_BITS))
					next_state = OWLR_ACKWT;
				// low stop after 16 bits: end of stream or ack wait
				else if (nbits == 5'(FRAME_BITS) && !line && low_cnt >= CNT_W'(ACK_VALID_CYCLES))
				begin
					next_cnt = '0;
					next_state = OWLR_ACKWT;
				end
				// high end-of-stream only after the full 16-bit frame; long lows fall to shutdown
				else if (line && high_cnt >= CNT_W'(EOS_CYCLES) && nbits == 5'(FRAME_BITS))
				begin
					next_state = OWLR_ACKWT;
					next_cnt = '0;
				end
				else if (!line && low_cnt >= CNT_W'(SHUTDOWN - 1))
					next_state = OWLR_OFF;
			end
			OWLR_ACKWT:
			begin
				// level only from a full valid frame
				if (valid)
					next_level = shift[LEVEL_MSB:0];
				next_done = valid;
				next_cnt = '0;
				// acknowledge only when asked and valid
				if (valid && shift[ACK_REQ_POS])
					next_state = OWLR_ACK;
				else
					next_state = OWLR_IDLE;
				next_nbits = '0;
			end
			// pull-down held for the acknowledge pulse time
			OWLR_ACK:
			begin
				if (cnt >= CNT_W'(ACK_PULSE - 1))
				begin
					next_cnt = '0;
					next_state = OWLR_IDLE;
				end
			end
			default:
				next_state = OWLR_OFF;
		endcase
	end

	always_ff @(posedge CLK_IN or negedge RESETN_IN)
	begin
		if (!RESETN_IN)
		begin
			state    <= OWLR_OFF;
			cnt      <= '0;
			low_cnt  <= '0;
			high_cnt <= '0;
			win_cnt  <= '0;
			shift    <= '0;
			nbits    <= '0;
			// full scale after power reset only
			level    <= LEVEL_RESET;
			done     <= 1'h0;
			data_open <= 1'h0;
		end
		else
		begin
			state    <= next_state;
			cnt      <= next_cnt;
			low_cnt  <= next_low_cnt;
			high_cnt <= next_high_cnt;
			win_cnt  <= next_win_cnt;
			shift    <= next_shift;
			nbits    <= next_nbits;
			level    <= next_level;
			done     <= next_done;
			data_open <= next_data_open;
		end
	end

	// open drain: only ever drive low
	assign CTRL_OUT          = 1'h0;
	assign CTRL_OE_OUT       = (state == OWLR_ACK);
	assign LEVEL_OUT         = level;
	assign ENABLED_OUT       = (state != OWLR_OFF);
	assign ONE_WIRE_MODE_OUT = (state == OWLR_IDLE) || (state == OWLR_BITS)
		|| (state == OWLR_ACKWT) || (state == OWLR_ACK);
	assign FRAME_DONE_OUT    = done;
endmodule

// >>> test/owlr_host.sv
`timescale 1ns/1ps
module owlr_host (
	// clock and line
	input  wire logic clk_in,
	input  wire logic line_in,
	output logic      pull_low_out
);
	initial pull_low_out = 1'h0;
	// called just after a falling edge
	task automatic hold(input logic v, input int n);
		pull_low_out = !v;
		repeat (n) @(negedge clk_in);
	endtask
	task automatic send_byte(input logic [7:0] b);
		hold(1'h1, 210);
		for (int i = 7; i >= 0; i--)
		begin
			hold(1'h0, b[i] ? 10 : 20);
			hold(1'h1, b[i] ? 20 : 10);
		end
		hold(1'h0, 210);
	endtask
	task automatic send_frame(input logic [7:0] a, input logic [7:0] d, output logic ack);
		send_byte(a);
		send_byte(d);
		hold(1'h1, 8);
		ack = !line_in;
		hold(1'h1, 210);
	endtask
endmodule

// >>> test/owlr_top_asserts.sv
`timescale 1ns/1ps
module owlr_top_asserts
	import owlr_pkg::*;
#(
	parameter int ACK_PULSE = ACK_PULSE_CYCLES,
	parameter int SHUTDOWN  = SHUTDOWN_CYCLES
)
(
	input wire logic       CLK_IN,
	input wire logic       RESETN_IN,
	input wire logic       CTRL_IN,
	input wire logic       CTRL_OUT,
	input wire logic       CTRL_OE_OUT,
	input wire logic [4:0] LEVEL_OUT,
	input wire logic       ENABLED_OUT,
	input wire logic       ONE_WIRE_MODE_OUT,
	input wire logic       FRAME_DONE_OUT
);
	// no saturation: a run never holds the line low for 2^20 cycles
	logic [19:0] low_cnt;
	logic [19:0] oe_cnt;
	logic [19:0] next_low_cnt;
	logic [19:0] next_oe_cnt;
	always_comb
	begin
		next_low_cnt = CTRL_IN ? 20'h00000 : low_cnt + 20'h00001;
		next_oe_cnt  = CTRL_OE_OUT ? oe_cnt + 20'h00001 : 20'h00000;
	end
	always_ff @(posedge CLK_IN or negedge RESETN_IN)
	begin
		if (!RESETN_IN)
		begin
			low_cnt <= 20'h00000;
			oe_cnt  <= 20'h00000;
		end
		else
		begin
			low_cnt <= next_low_cnt;
			oe_cnt  <= next_oe_cnt;
		end
	end
	default clocking @(posedge CLK_IN);
	endclocking
	default disable iff (!RESETN_IN);
	sequence s_ack_rise;
		$rose(CTRL_OE_OUT);
	endsequence
	a_drain_only: assert property (CTRL_OUT == 1'h0)
		else $error("data pin not low");
	a_ack_length: assert property (oe_cnt <= 20'(ACK_PULSE))
		else $error("acknowledge too long");
	a_ack_delay: assert property (s_ack_rise |-> low_cnt >= 20'(ACK_VALID_CYCLES))
		else $error("acknowledge too early");
	a_ack_valid_frame: assert property (s_ack_rise |-> FRAME_DONE_OUT)
		else $error("acknowledge without frame");
	a_level_on_done: assert property ($changed(LEVEL_OUT) |-> FRAME_DONE_OUT)
		else $error("level changed outside frame");
	a_done_pulse: assert property (FRAME_DONE_OUT |=> !FRAME_DONE_OUT)
		else $error("done longer than one cycle");
	a_ack_in_mode: assert property (CTRL_OE_OUT |-> ONE_WIRE_MODE_OUT && ENABLED_OUT)
		else $error("acknowledge outside mode");
	a_mode_enabled: assert property (ONE_WIRE_MODE_OUT |-> ENABLED_OUT)
		else $error("mode while shut down");
	a_shutdown_low: assert property (low_cnt > 20'(SHUTDOWN + 8) |-> !ENABLED_OUT)
		else $error("no shutdown on long low");
endmodule

// >>> test/owlr_top_tb.sv
`timescale 1ns/1ps
module owlr_top_tb;
	import owlr_pkg::*;
	logic       clk;
	logic       rst_n;
	logic       line;
	logic       pull_low;
	logic       oe;
	logic [4:0] level;
	logic       en;
	logic       mode;
	logic       ack;
	int         bad_count;
	int         tests_run;
	int         cyc;
	int         done_cnt;
	int         done_seen;
	logic       done;
	logic [7:0] addr [5] = '{8'h72, 8'h72, 8'h4E, 8'h72, 8'h72};
	logic [7:0] data [5] = '{8'h8A, 8'h15, 8'h80, 8'hC3, 8'h00};
	logic [4:0] lvl  [5] = '{5'h0A, 5'h15, 5'h15, 5'h15, 5'h00};
	logic       ackx [5] = '{1'h1, 1'h0, 1'h0, 1'h0, 1'h0};
	logic       okx  [5] = '{1'h1, 1'h1, 1'h0, 1'h0, 1'h1};
	// pull-up wins unless a party pulls low
	assign line = !(pull_low || oe);
	initial
	begin
		clk = 1'h0;
		forever #5 clk = ~clk;
	end
	owlr_host owlr_host_i (.clk_in(clk), .line_in(line), .pull_low_out(pull_low));
	owlr_top #(.ACK_PULSE(50), .MODE_DELAY(10), .MODE_LOW(20), .MODE_WIN(100), .SHUTDOWN(300)) owlr_top_i (
		.CLK_IN(clk), .RESETN_IN(rst_n), .CTRL_IN(line), .CTRL_OUT(), .CTRL_OE_OUT(oe),
		.LEVEL_OUT(level), .ENABLED_OUT(en), .ONE_WIRE_MODE_OUT(mode), .FRAME_DONE_OUT(done));
	// done pulses counted away from the edge that launches them
	always @(negedge clk)
	begin
		if (done)
			done_cnt++;
	end
	task automatic check(input logic [4:0] got, input logic [4:0] exp);
		tests_run++;
		if (got !== exp)
			$display("unexpected at %0t: got %h want %h", $time, got, exp);
		if (got !== exp)
			bad_count++;
	endtask
	task automatic print_verdict();
		$display("comparisons %0d mismatches %0d", tests_run, bad_count);
		if (bad_count == 0 && tests_run > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask
	// rise, wait past delay, long low inside window
	task automatic enter();
		owlr_host_i.hold(1'h0, 10);
		owlr_host_i.hold(1'h1, 20);
		owlr_host_i.hold(1'h0, 30);
		owlr_host_i.hold(1'h1, 20);
	endtask
	always @(posedge clk)
	begin
		cyc++;
		if (cyc == 20000)
		begin
			bad_count++;
			print_verdict();
		end
	end
	initial
	begin
		rst_n = 1'h0;
		repeat (16) @(negedge clk);
		rst_n = 1'h1;
		check(level, LEVEL_RESET);
		check({4'h0, en}, 5'h00);
		enter();
		check({4'h0, mode}, 5'h01);
		$display("mode entry test done");
		for (int i = 0; i < 5; i++)
		begin
			done_seen = done_cnt;
			owlr_host_i.send_frame(addr[i], data[i], ack);
			check(level, lvl[i]);
			check(5'(done_cnt - done_seen), {4'h0, okx[i]});
			check({4'h0, ack}, {4'h0, ackx[i]});
			$display("frame test %0d done", i);
		end
		owlr_host_i.hold(1'h0, 310);
		check({4'h0, en}, 5'h00);
		check(level, 5'h00);
		$display("shutdown test done");
		owlr_host_i.hold(1'h1, 150);
		check({4'h0, en}, 5'h01);
		check({4'h0, mode}, 5'h00);
		owlr_host_i.hold(1'h0, 310);
		check({4'h0, en}, 5'h00);
		$display("pwm mode test done");
		enter();
		owlr_host_i.send_frame(DEV_ADDR, 8'h9F, ack);
		check(level, 5'h1F);
		check({4'h0, ack}, 5'h01);
		$display("restart test done");
		print_verdict();
	end
endmodule
bind owlr_top owlr_top_asserts #(.ACK_PULSE(ACK_PULSE), .SHUTDOWN(SHUTDOWN)) owlr_top_asserts_i (
	.CLK_IN(CLK_IN), .RESETN_IN(RESETN_IN), .CTRL_IN(CTRL_IN), .CTRL_OUT(CTRL_OUT), .CTRL_OE_OUT(CTRL_OE_OUT),
	.LEVEL_OUT(LEVEL_OUT), .ENABLED_OUT(ENABLED_OUT), .ONE_WIRE_MODE_OUT(ONE_WIRE_MODE_OUT),
	.FRAME_DONE_OUT(FRAME_DONE_OUT));
